// File: hw/imu_pwr_regs.vh
// Purpose: Register map, field positions, reset values and timing counts
//          of the power and interrupt pin configuration block.
// Assumes: Eight-bit registers on an eight-bit register address.
// Notes:   Included by bare name from the design files.
`ifndef IMU_PWR_REGS_VH
`define IMU_PWR_REGS_VH

// Register offsets.
`define OFS_MAIN_POWER_CONTROL 8'h06
`define OFS_SENSOR_POWER_ENABLE 8'h07
`define OFS_INTERRUPT_PIN_CONFIG 8'h0f
`define OFS_AUX_MASTER_STATUS 8'h17
`define OFS_PRIMARY_IRQ_STATUS 8'h19

// Reset values.
`define RST_MAIN_POWER_CONTROL 8'h41
`define RST_SENSOR_POWER_ENABLE 8'h00
`define RST_INTERRUPT_PIN_CONFIG 8'h00

// Writable bits; reserved and self-clearing bits are never stored.
`define MSK_MAIN_POWER_CONTROL 8'h6f
`define MSK_SENSOR_POWER_ENABLE 8'h3f
`define MSK_INTERRUPT_PIN_CONFIG 8'hfe

// Main power control fields.
`define BIT_DEFAULT_RESTORE 7
`define BIT_SLEEP 6
`define BIT_DIGITAL_LOW_POWER_ENABLE 5
`define BIT_THERMAL_SENSOR_OFF 3
`define CLOCK_SOURCE_CODE 2:0

// Sensor power fields.
`define ACCEL_AXIS_OFF 5:3
`define GYRO_AXIS_OFF 2:0

// Interrupt pin configuration fields.
`define BIT_IRQ_LINE_POLARITY 7
`define BIT_IRQ_LINE_DRIVE 6
`define BIT_IRQ_LINE_LATCH 5
`define BIT_STATUS_CLEAR_ON_ANY_READ 4
`define BIT_FRAME_SYNC_POLARITY 3
`define BIT_FRAME_SYNC_IRQ_ENABLE 2
`define BIT_AUX_PIN_PASSTHROUGH 1

// Frame sync event flag position in the aux master status register.
`define BIT_FRAME_SYNC_EVENT_FLAG 7

// Clock source codes.
`define CLK_CODE_STOP 3'h7
`define CLK_CODE_OSC_A 3'h0
`define CLK_CODE_OSC_B 3'h6

// Timing: interrupt pulse width and the clock rate it is counted at.
`define IRQ_PULSE_NS 50000
`define MCLK_PERIOD_NS 5
`define IRQ_PULSE_CYCLES (`IRQ_PULSE_NS / `MCLK_PERIOD_NS)

`endif

// File: hw/irq_pulse_gen.v
// Purpose: Stretches a one-cycle trigger into a fixed-width pulse.
// Assumes: Synchronous active-low reset on i_mclk.
// Notes:   A trigger during a pulse restarts the full width.
`default_nettype none

module irq_pulse_gen #(
  parameter integer PULSE_CYCLES = 10000,
  parameter integer CNT_W = 14
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Trigger and pulse
  input wire i_trigger,
  output reg o_pulse
);

  localparam integer LAST_I = PULSE_CYCLES - 1;
  localparam [CNT_W-1:0] LAST = LAST_I[CNT_W-1:0];

  reg [CNT_W-1:0] count_q;

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      count_q <= {CNT_W{1'b0}};
      o_pulse <= 1'b0;
    end else if (i_trigger) begin
      count_q <= LAST;
      o_pulse <= 1'b1;
    end else if (count_q != {CNT_W{1'b0}}) begin
      count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      o_pulse <= 1'b0;
    end
  end

endmodule // irq_pulse_gen

`default_nettype wire

// File: hw/imu_power_and_irq_pin_config.v
// Purpose: Power management and interrupt pin configuration registers
//          with the logic they steer.
// Assumes: Register port requests are single-cycle strobes; all inputs
//          are synchronous to i_mclk.
// Notes on behaviour
// - Default-restore bit reloads registers, then self-clears.
// - Sleep bit powers analog off; clearing wakes.
// - Low-power bit switches digital low-current feature only.
// - Low-power bit ignored in sensor low-noise mode.
// - Thermal-off bit disables the temperature sensor.
// - Clock codes 0 and 6 pick oscillator.
// - Codes 1 to 5 pick PLL when ready.
// - Code 7 stops clock, holds timing reset.
// - Gyro field 111 all off, 000 on.
// - Accel field 000 powers all axes.
// - Polarity bit makes interrupt line active low.
// - Drive bit selects open-drain or push-pull.
// - Latch holds line until clear, else pulse.
// - Any-read clear option zeroes primary status.
// - Any-read clear leaves secondary status alone.
// - Frame sync polarity bit sets input active level.
// - Enabled frame sync edge sets event flag.
// - Bypass mirrors host serial pins onto aux.
`default_nettype none
`include "imu_pwr_regs.vh"

module imu_power_and_irq_pin_config #(
  parameter integer STATUS_W = 4,
  parameter integer IRQ_PULSE_CYCLES = `IRQ_PULSE_CYCLES,
  parameter integer PULSE_CNT_W = 14
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Register port
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  output reg o_reg_rvalid,
  // Sensor and clock status
  input wire i_sensors_low_noise,
  input wire i_pll_ready,
  // Interrupt sources
  input wire [STATUS_W-1:0] i_primary_irq_evt,
  input wire i_secondary_irq_pending,
  input wire i_frame_sync_pin,
  // Aux bus bypass sources
  input wire i_aux_master_enable,
  input wire i_host_data_pin,
  input wire i_host_clock_pin,
  // Power and clock controls
  output reg o_analog_power_on,
  output reg o_digital_low_power,
  output reg o_thermal_sensor_on,
  output reg o_clk_use_pll,
  output reg o_clk_running,
  output reg o_timing_gen_reset,
  output reg [2:0] o_gyro_axis_en,
  output reg [2:0] o_accel_axis_en,
  // Interrupt line pin
  output reg o_irq_line_one_o,
  output reg o_irq_line_one_oe,
  // Aux bus pins, open drain
  output reg o_aux_bus_clock_pin_o,
  output reg o_aux_bus_clock_pin_oe,
  output reg o_aux_bus_data_pin_o,
  output reg o_aux_bus_data_pin_oe,
  output reg o_aux_bypass_active
);

  reg [7:0] main_power_control_q;
  reg [7:0] main_power_control_d;
  reg [7:0] sensor_power_enable_q;
  reg [7:0] sensor_power_enable_d;
  reg [7:0] interrupt_pin_config_q;
  reg [7:0] interrupt_pin_config_d;
  reg [STATUS_W-1:0] primary_irq_status_q;
  reg [STATUS_W-1:0] primary_irq_status_d;
  reg frame_sync_flag_q;
  reg frame_sync_flag_d;
  reg frame_sync_active_q;
  reg secondary_q;

  wire wr_main = i_reg_wr && (i_reg_addr == `OFS_MAIN_POWER_CONTROL);
  wire wr_sensor = i_reg_wr && (i_reg_addr == `OFS_SENSOR_POWER_ENABLE);
  wire wr_pin = i_reg_wr && (i_reg_addr == `OFS_INTERRUPT_PIN_CONFIG);
  wire rd_status = i_reg_rd && (i_reg_addr == `OFS_PRIMARY_IRQ_STATUS);
  wire rd_aux = i_reg_rd && (i_reg_addr == `OFS_AUX_MASTER_STATUS);
  wire restore = wr_main && i_reg_wdata[`BIT_DEFAULT_RESTORE];

  wire any_rd_clr = interrupt_pin_config_q[`BIT_STATUS_CLEAR_ON_ANY_READ];
  wire irq_latch = interrupt_pin_config_q[`BIT_IRQ_LINE_LATCH];
  wire irq_pol = interrupt_pin_config_q[`BIT_IRQ_LINE_POLARITY];
  wire irq_od = interrupt_pin_config_q[`BIT_IRQ_LINE_DRIVE];
  wire fs_pol = interrupt_pin_config_q[`BIT_FRAME_SYNC_POLARITY];
  wire fs_en = interrupt_pin_config_q[`BIT_FRAME_SYNC_IRQ_ENABLE];
  wire passthru = interrupt_pin_config_q[`BIT_AUX_PIN_PASSTHROUGH];
  wire [2:0] clk_code = main_power_control_q[`CLOCK_SOURCE_CODE];

  // Frame sync qualified to its active level, then edge detected.
  wire fs_active = i_frame_sync_pin ^ fs_pol;
  wire fs_event = fs_en && fs_active && !frame_sync_active_q;

  wire prim_new = |(i_primary_irq_evt & ~primary_irq_status_q);
  wire sec_rise = i_secondary_irq_pending && !secondary_q;
  wire pulse_trig = prim_new || (fs_event && !frame_sync_flag_q) ||
                    sec_rise;
  wire irq_pulse;

  // Configuration registers. A restore write wins over everything and the
  // restore bit itself is never stored, so it always reads back as zero.
  always @* begin
    main_power_control_d = main_power_control_q;
    sensor_power_enable_d = sensor_power_enable_q;
    interrupt_pin_config_d = interrupt_pin_config_q;
    if (restore) begin
      main_power_control_d = `RST_MAIN_POWER_CONTROL;
      sensor_power_enable_d = `RST_SENSOR_POWER_ENABLE;
      interrupt_pin_config_d = `RST_INTERRUPT_PIN_CONFIG;
    end else begin
      if (wr_main) begin
        main_power_control_d = i_reg_wdata & `MSK_MAIN_POWER_CONTROL;
      end
      if (wr_sensor) begin
        sensor_power_enable_d = i_reg_wdata & `MSK_SENSOR_POWER_ENABLE;
      end
      if (wr_pin) begin
        interrupt_pin_config_d = i_reg_wdata & `MSK_INTERRUPT_PIN_CONFIG;
      end
    end
  end

  // Status. Clears come first and new events are OR-ed in after, so an
  // event landing in the clearing cycle survives.
  always @* begin
    primary_irq_status_d = primary_irq_status_q;
    frame_sync_flag_d = frame_sync_flag_q;
    if (rd_status || (i_reg_rd && any_rd_clr)) begin
      primary_irq_status_d = {STATUS_W{1'b0}};
    end
    if (rd_aux) begin
      // The frame sync flag keeps its own read-to-clear.
      frame_sync_flag_d = 1'b0;
    end
    primary_irq_status_d = primary_irq_status_d | i_primary_irq_evt;
    if (fs_event) begin
      frame_sync_flag_d = 1'b1;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      main_power_control_q <= `RST_MAIN_POWER_CONTROL;
      sensor_power_enable_q <= `RST_SENSOR_POWER_ENABLE;
      interrupt_pin_config_q <= `RST_INTERRUPT_PIN_CONFIG;
      primary_irq_status_q <= {STATUS_W{1'b0}};
      frame_sync_flag_q <= 1'b0;
      frame_sync_active_q <= 1'b0;
      secondary_q <= 1'b0;
    end else begin
      main_power_control_q <= main_power_control_d;
      sensor_power_enable_q <= sensor_power_enable_d;
      interrupt_pin_config_q <= interrupt_pin_config_d;
      primary_irq_status_q <= primary_irq_status_d;
      frame_sync_flag_q <= frame_sync_flag_d;
      frame_sync_active_q <= fs_active;
      secondary_q <= i_secondary_irq_pending;
    end
  end

  // Read port: data one cycle after the strobe, unmapped reads as zero.
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `OFS_MAIN_POWER_CONTROL: begin
            o_reg_rdata <= main_power_control_q;
          end
          `OFS_SENSOR_POWER_ENABLE: begin
            o_reg_rdata <= sensor_power_enable_q;
          end
          `OFS_INTERRUPT_PIN_CONFIG: begin
            o_reg_rdata <= interrupt_pin_config_q;
          end
          `OFS_PRIMARY_IRQ_STATUS: begin
            o_reg_rdata <= {{(8-STATUS_W){1'b0}}, primary_irq_status_q};
          end
          `OFS_AUX_MASTER_STATUS: begin
            o_reg_rdata <= {frame_sync_flag_q, 7'h00};
          end
          default: begin
            o_reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  // Pulse width is long, so the count is a parameter a bench may shorten.
  irq_pulse_gen #(
    .PULSE_CYCLES(IRQ_PULSE_CYCLES),
    .CNT_W(PULSE_CNT_W)
  ) u_irq_pulse (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_trigger(pulse_trig),
    .o_pulse(irq_pulse)
  );

  // Asserted interrupt state before polarity and drive are applied.
  wire irq_level = (|primary_irq_status_q) || frame_sync_flag_q ||
                   i_secondary_irq_pending;
  wire irq_assert = irq_latch ? irq_level : irq_pulse;
  wire irq_pin_level = irq_assert ^ irq_pol;

  // Open drain only ever pulls low; a high level relies on the pull-up.
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_irq_line_one_o <= 1'b0;
      o_irq_line_one_oe <= 1'b1;
    end else if (irq_od) begin
      o_irq_line_one_o <= 1'b0;
      o_irq_line_one_oe <= !irq_pin_level;
    end else begin
      o_irq_line_one_o <= irq_pin_level;
      o_irq_line_one_oe <= 1'b1;
    end
  end

  // Power and clock controls.
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_analog_power_on <= 1'b0;
      o_digital_low_power <= 1'b0;
      o_thermal_sensor_on <= 1'b1;
      o_clk_use_pll <= 1'b0;
      o_clk_running <= 1'b1;
      o_timing_gen_reset <= 1'b0;
      o_gyro_axis_en <= 3'h7;
      o_accel_axis_en <= 3'h7;
    end else begin
      o_analog_power_on <= !main_power_control_q[`BIT_SLEEP];
      o_digital_low_power <=
        main_power_control_q[`BIT_DIGITAL_LOW_POWER_ENABLE] &&
        !i_sensors_low_noise;
      o_thermal_sensor_on <=
        !main_power_control_q[`BIT_THERMAL_SENSOR_OFF];
      // Per-axis inversion; only all-on and all-off codes are meaningful.
      o_gyro_axis_en <= ~sensor_power_enable_q[`GYRO_AXIS_OFF];
      o_accel_axis_en <=
        ~sensor_power_enable_q[`ACCEL_AXIS_OFF];
      case (clk_code)
        `CLK_CODE_OSC_A, `CLK_CODE_OSC_B: begin
          o_clk_use_pll <= 1'b0;
          o_clk_running <= 1'b1;
          o_timing_gen_reset <= 1'b0;
        end
        `CLK_CODE_STOP: begin
          o_clk_use_pll <= 1'b0;
          o_clk_running <= 1'b0;
          o_timing_gen_reset <= 1'b1;
        end
        default: begin
          // Falls back to the oscillator while the PLL is not ready.
          o_clk_use_pll <= i_pll_ready;
          o_clk_running <= 1'b1;
          o_timing_gen_reset <= 1'b0;
        end
      endcase
    end
  end

  // Aux bus bypass. Host pins are mirrored as open drain so either side
  // may hold the line low; the master engine itself is not in this block.
  wire bypass = passthru && !i_aux_master_enable;

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_aux_bypass_active <= 1'b0;
      o_aux_bus_clock_pin_o <= 1'b0;
      o_aux_bus_clock_pin_oe <= 1'b0;
      o_aux_bus_data_pin_o <= 1'b0;
      o_aux_bus_data_pin_oe <= 1'b0;
    end else begin
      o_aux_bypass_active <= bypass;
      o_aux_bus_clock_pin_o <= 1'b0;
      o_aux_bus_data_pin_o <= 1'b0;
      o_aux_bus_clock_pin_oe <= bypass && !i_host_clock_pin;
      o_aux_bus_data_pin_oe <= bypass && !i_host_data_pin;
    end
  end

endmodule // imu_power_and_irq_pin_config

`default_nettype wire

// File: dv/pwr_cfg_asserts.sv
// Purpose: Port assertions for the power and interrupt pin block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Controls follow an input one cycle and a write two cycles later.
`default_nettype none
module pwr_cfg_asserts (
  // Clock, reset and register port
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  // Status inputs
  input wire logic i_sensors_low_noise,
  input wire logic i_pll_ready,
  input wire logic i_aux_master_enable,
  input wire logic i_host_data_pin,
  input wire logic i_host_clock_pin,
  // Controls and pins
  input wire logic o_analog_power_on,
  input wire logic o_digital_low_power,
  input wire logic o_thermal_sensor_on,
  input wire logic o_clk_use_pll,
  input wire logic o_clk_running,
  input wire logic o_timing_gen_reset,
  input wire logic [2:0] o_gyro_axis_en,
  input wire logic [2:0] o_accel_axis_en,
  input wire logic o_aux_bus_clock_pin_oe,
  input wire logic o_aux_bus_data_pin_oe,
  input wire logic o_aux_bypass_active
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // A restore write reloads defaults, so it is kept out of the field checks.
  sequence main_wr;
    i_reg_wr && i_reg_addr == 8'h06 && !i_reg_wdata[7];
  endsequence
  sequence stop_wr;
    main_wr ##0 i_reg_wdata[2:0] == 3'h7;
  endsequence
  sleep_power_a: assert property (
    main_wr |-> ##2 o_analog_power_on == !$past(i_reg_wdata[6], 2))
    else $error("analog power wrong");
  thermal_off_a: assert property (
    main_wr |-> ##2 o_thermal_sensor_on == !$past(i_reg_wdata[3], 2))
    else $error("thermal sensor wrong");
  clock_stop_a: assert property (
    stop_wr |-> ##2 !o_clk_running && o_timing_gen_reset)
    else $error("clock not stopped");
  low_noise_a: assert property (
    i_sensors_low_noise |=> !o_digital_low_power)
    else $error("low power not ignored");
  pll_ready_a: assert property (
    o_clk_use_pll |-> $past(i_pll_ready))
    else $error("pll used while not ready");
  axis_enable_a: assert property (
    i_reg_wr && i_reg_addr == 8'h07 |-> ##2
    {o_accel_axis_en, o_gyro_axis_en} == ~$past(i_reg_wdata[5:0], 2))
    else $error("axis enables wrong");
  bypass_mirror_a: assert property (
    o_aux_bypass_active |->
    o_aux_bus_clock_pin_oe == !$past(i_host_clock_pin) &&
    o_aux_bus_data_pin_oe == !$past(i_host_data_pin))
    else $error("bypass pins wrong");
  master_isolate_a: assert property (
    i_aux_master_enable |=> !o_aux_bypass_active &&
    !o_aux_bus_clock_pin_oe && !o_aux_bus_data_pin_oe)
    else $error("bypass while master on");
endmodule // pwr_cfg_asserts

bind imu_power_and_irq_pin_config pwr_cfg_asserts u_asserts (
  .i_mclk, .i_rst_n, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
  .i_sensors_low_noise, .i_pll_ready, .i_aux_master_enable,
  .i_host_data_pin, .i_host_clock_pin, .o_analog_power_on,
  .o_digital_low_power, .o_thermal_sensor_on, .o_clk_use_pll,
  .o_clk_running, .o_timing_gen_reset, .o_gyro_axis_en,
  .o_accel_axis_en, .o_aux_bus_clock_pin_oe, .o_aux_bus_data_pin_oe,
  .o_aux_bypass_active);
`default_nettype wire

// File: dv/host_reg_model.sv
// Purpose: Host side of the register port, one strobe per transfer.
// Assumes: Requests start 1 ns after a rising edge.
// Notes:   Reads return unknown data if the valid strobe is missing.
`default_nettype none
module host_reg_model (
  // Clock and answers
  input wire logic i_mclk,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  // Requests
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata} = 18'h0;
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(posedge i_mclk);
    #1;
    o_reg_wr = w;
    o_reg_rd = !w;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_mclk);
    #1;
    {o_reg_wr, o_reg_rd} = 2'b00;
    // Idle lines show the inverse so stale values never pass as fresh.
    {o_reg_addr, o_reg_wdata} = ~{a, d};
    q = i_reg_rvalid ? i_reg_rdata : 8'hxx;
  endtask
endmodule // host_reg_model
`default_nettype wire

// File: dv/tb_imu_power_and_irq_pin_config.sv
// Purpose: Self-checking bench for the power and interrupt pin block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   The interrupt pulse is shortened to 8 cycles to keep runs short.
`default_nettype none
module tb_imu_power_and_irq_pin_config;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_mclk = 0, i_rst_n = 0, i_sensors_low_noise = 0, i_pll_ready = 0;
  logic i_secondary_irq_pending = 0, i_frame_sync_pin = 0;
  logic i_aux_master_enable = 0, i_host_data_pin = 1, i_host_clock_pin = 1;
  logic [3:0] i_primary_irq_evt = 4'h0;
  logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_analog_power_on;
  logic o_digital_low_power, o_thermal_sensor_on, o_clk_use_pll;
  logic o_clk_running, o_timing_gen_reset, o_irq_line_one_o;
  logic o_irq_line_one_oe, o_aux_bus_clock_pin_oe, o_aux_bus_data_pin_oe;
  logic o_aux_bypass_active, o_aux_bus_clock_pin_o, o_aux_bus_data_pin_o;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, q;
  logic [2:0] o_gyro_axis_en, o_accel_axis_en;
  int checked = 0, mismatches = 0;
  always #2.5 i_mclk = ~i_mclk;
  imu_power_and_irq_pin_config #(.IRQ_PULSE_CYCLES(8)) dut (
    .i_mclk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_rvalid, .i_sensors_low_noise, .i_pll_ready,
    .i_primary_irq_evt, .i_secondary_irq_pending, .i_frame_sync_pin,
    .i_aux_master_enable, .i_host_data_pin, .i_host_clock_pin,
    .o_analog_power_on, .o_digital_low_power, .o_thermal_sensor_on,
    .o_clk_use_pll, .o_clk_running, .o_timing_gen_reset, .o_gyro_axis_en,
    .o_accel_axis_en, .o_irq_line_one_o, .o_irq_line_one_oe,
    .o_aux_bus_clock_pin_o, .o_aux_bus_clock_pin_oe,
    .o_aux_bus_data_pin_o, .o_aux_bus_data_pin_oe, .o_aux_bypass_active);
  host_reg_model host (.i_mclk, .i_reg_rdata(o_reg_rdata),
    .i_reg_rvalid(o_reg_rvalid), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
    .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic pin(input logic act, input logic [7:0] c);
    chk({o_irq_line_one_o, o_irq_line_one_oe},
        c[6] ? {1'b0, !(act ^ c[7])} : {act ^ c[7], 1'b1});
  endtask
  // Aux pins are open drain, so their data outputs must always stay low.
  task automatic byp(input logic [2:0] e);
    chk({o_aux_bypass_active, o_aux_bus_clock_pin_oe, o_aux_bus_data_pin_oe,
         o_aux_bus_clock_pin_o, o_aux_bus_data_pin_o}, {e, 2'b00});
  endtask
  task automatic t_regs;
    rdc(8'h06, 8'h41);
    rdc(8'h20, 8'h00);
    wrr(8'h07, 8'h3f);
    step(1);
    chk({o_accel_axis_en, o_gyro_axis_en}, 8'h00);
    rdc(8'h07, 8'h3f);
    wrr(8'h0f, 8'h20);
    wrr(8'h06, 8'h80);
    step(1);
    chk({o_accel_axis_en, o_gyro_axis_en,
         o_analog_power_on}, 8'h7e);
    rdc(8'h06, 8'h41);
    rdc(8'h0f, 8'h00);
    $display("register test done");
  endtask
  task automatic t_power;
    logic [2:0] e;
    wrr(8'h06, 8'h28);
    step(1);
    chk({o_analog_power_on, o_thermal_sensor_on,
         o_digital_low_power}, 8'h05);
    i_sensors_low_noise = 1'b1;
    step(1);
    chk(o_digital_low_power, 8'h00);
    i_sensors_low_noise = 1'b0;
    wrr(8'h06, 8'h7f);
    rdc(8'h06, 8'h6f);
    i_pll_ready = 1'b1;
    for (int c = 0; c < 8; c++) begin
      wrr(8'h06, 8'(c));
      step(1);
      e = {c > 0 && c < 6, c != 7, c == 7};
      chk({o_clk_use_pll, o_clk_running,
           o_timing_gen_reset}, e);
    end
    i_pll_ready = 1'b0;
    wrr(8'h06, 8'h01);
    step(1);
    chk(o_clk_use_pll, 8'h00);
    $display("power test done");
  endtask
  task automatic t_irq;
    int n;
    for (int k = 0; k < 4; k++) begin
      wrr(8'h0f, {k[1:0], 6'h20});
      i_primary_irq_evt = 4'h1;
      step(1);
      i_primary_irq_evt = 4'h0;
      step(1);
      pin(1'b1, {k[1:0], 6'h20});
      rdc(8'h19, 8'h01);
      step(1);
      pin(1'b0, {k[1:0], 6'h20});
    end
    for (int a = 0; a < 2; a++) begin
      wrr(8'h0f, a ? 8'h30 : 8'h20);
      i_primary_irq_evt = 4'h2;
      step(1);
      i_primary_irq_evt = 4'h0;
      rdc(8'h07, 8'h00);
      rdc(8'h19, a ? 8'h00 : 8'h02);
    end
    i_secondary_irq_pending = 1'b1;
    rdc(8'h07, 8'h00);
    step(1);
    pin(1'b1, 8'h30);
    i_secondary_irq_pending = 1'b0;
    wrr(8'h0f, 8'h00);
    step(10);
    i_primary_irq_evt = 4'h4;
    step(1);
    i_primary_irq_evt = 4'h0;
    n = 0;
    repeat (20) begin
      step(1);
      n += o_irq_line_one_o;
    end
    chk(8'(n), 8'h08);
    rdc(8'h19, 8'h04);
    $display("interrupt test done");
  endtask
  task automatic t_frame_sync_pin;
    i_frame_sync_pin = 1'b1;
    step(2);
    rdc(8'h17, 8'h00);
    wrr(8'h0f, 8'h04);
    i_frame_sync_pin = 1'b0;
    step(2);
    i_frame_sync_pin = 1'b1;
    step(2);
    rdc(8'h17, 8'h80);
    wrr(8'h0f, 8'h0c);
    step(2);
    rdc(8'h17, 8'h00);
    i_frame_sync_pin = 1'b0;
    step(2);
    rdc(8'h17, 8'h80);
    $display("frame sync test done");
  endtask
  task automatic t_bypass;
    wrr(8'h0f, 8'h02);
    i_host_clock_pin = 1'b0;
    step(2);
    byp(3'h6);
    i_host_clock_pin = 1'b1;
    i_host_data_pin = 1'b0;
    step(1);
    byp(3'h5);
    i_aux_master_enable = 1'b1;
    step(1);
    byp(3'h0);
    $display("bypass test done");
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    step(5);
    i_rst_n = 1'b1;
    t_regs;
    t_power;
    t_irq;
    t_frame_sync_pin;
    t_bypass;
    results;
  end
  initial begin
    repeat (4000) @(posedge i_mclk);
    mismatches++;
    results;
  end
endmodule // tb_imu_power_and_irq_pin_config
`default_nettype wire
